// ==== rtl/usc_pkg.sv ====
// constants, field layout and carriers for the serial port control block
// assumes one 100 MHz clock and a baud enable at sixteen times the bit rate
//
// Contract
// - bit 7 picks frame format: clear 8-bit, set 9-bit
// - bit 6 always reads one, writes to it are ignored
// - 8-bit mode with check enabled: receive flag only when stop bit is one
// - 9-bit mode with check enabled: receive flag only when ninth bit is one
// - frames are accepted only while receive enable bit 4 is set
// - 9-bit mode sends bit 3 as ninth bit; unused in 8-bit mode
// - bit 2 takes stop bit (8-bit) or ninth bit (9-bit) on reception
// - transmit flag bit 1 sets at start of stop bit
// - transmit flag requests interrupt, only software clears it
// - receive flag bit 0 sets when accepted frame's stop bit is sampled
// - receive flag requests interrupt, only software clears it
// - control register sits at 0x98, all pages, bit addressable
// - data buffer write starts transmission, read returns receive latch
// - latch and bit 2 load only if receive flag clear, else frame dropped
// - 8-bit frame: start, eight data bits lsb first, stop
package usc_pkg;
    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] USC_CTRL_ADDR  = 8'h98;
    localparam logic [7:0] USC_DATA_ADDR  = 8'h99;
    localparam logic [4:0] USC_BIT_BASE   = 5'h13;
    localparam logic [7:0] USC_CTRL_RST   = 8'h40;
    localparam logic [7:0] USC_CTRL_ONES  = 8'h40;
    localparam logic [7:0] USC_CTRL_WMASK = 8'hBF;
    localparam logic [7:0] USC_UNMAPPED   = 8'h00;

    localparam int USC_B_MODE = 7;
    localparam int USC_B_RSVD = 6;
    localparam int USC_B_MCE  = 5;
    localparam int USC_B_REN  = 4;
    localparam int USC_B_TB8  = 3;
    localparam int USC_B_RB8  = 2;
    localparam int USC_B_TI   = 1;
    localparam int USC_B_RI   = 0;

    // ------------------------------------------------------------------
    // timing in baud enable pulses, last data bit index, fifo width and depth
    // ------------------------------------------------------------------
    localparam logic [3:0] USC_OVS_LAST = 4'hF;
    localparam logic [3:0] USC_MID      = 4'h7;
    localparam logic [2:0] USC_LAST_BIT = 3'h7;
    localparam int         USC_FIFO_W   = 8;
    localparam int         USC_FIFO_D   = 4;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
        logic       bit_wr;
        logic [7:0] bit_addr;
        logic       bit_val;
    } usc_sfr_req_t;

    typedef enum logic [2:0] {
        USC_IDLE,
        USC_START,
        USC_DATA,
        USC_NINTH,
        USC_STOP
    } usc_state_t;
endpackage

// ==== rtl/usc_fifo.sv ====
// small flip-flop fifo with valid/ready on both sides
// assumes both sides on the same clock; ready is low while full
`timescale 1ns/100ps
module usc_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;

    assign in_ready_o  = (cnt_q != (AW+1)'(D));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rd_ptr_q];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(D-1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(D-1)) ? '0 : rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // usc_fifo

// ==== rtl/usc_top.sv ====
// serial port control register with transmitter and receiver
// assumes sfr requests and baud enable from logic on clk_i; rx_i is a pin
`timescale 1ns/100ps
module usc_top (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire usc_pkg::usc_sfr_req_t sfr_req_i,
    output logic [7:0]                 sfr_rdata_o,
    input  wire logic                  baud_x16_i,
    input  wire logic                  rx_i,
    output logic                       tx_o,
    output logic                       irq_o,
    output logic                       tx_buf_full_o
);
    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [7:0]          ctl_q;
    logic [7:0]          sw_we;
    logic [7:0]          sw_val;
    logic [7:0]          hw_we;
    logic [7:0]          hw_val;
    logic [7:0]          rdata_q;
    logic                irq_q;
    logic                full_q;
    logic                fifo_in_valid;
    logic                fifo_in_ready;
    logic                fifo_out_valid;
    logic                fifo_out_ready;
    logic [7:0]          fifo_out_data;
    usc_pkg::usc_state_t tx_state_q;
    logic [3:0]          tx_tick_q;
    logic [2:0]          tx_bit_q;
    logic [7:0]          tx_shift_q;
    logic                tx_q;
    logic                tx_done_q;
    logic                tx_bit_end;
    logic                rx_s1_q;
    logic                rx_s2_q;
    logic                rx_s3_q;
    usc_pkg::usc_state_t rx_state_q;
    logic [3:0]          rx_tick_q;
    logic [2:0]          rx_bit_q;
    logic [7:0]          rx_shift_q;
    logic                rx_ninth_q;
    logic [7:0]          rx_latch_q;
    logic                rx_load_q;
    logic                rx_rb8_q;
    logic                rx_samp;
    logic                rx_stop_samp;
    logic                rx_stop_bit;
    logic                rx_check_bit;
    logic                rx_accept;
    logic                mode9;

    assign mode9 = ctl_q[usc_pkg::USC_B_MODE];

    // ------------------------------------------------------------------
    // register access decode
    // ------------------------------------------------------------------
    always_comb begin
        sw_we  = 8'h00;
        sw_val = 8'h00;
        if (sfr_req_i.wr && sfr_req_i.addr == usc_pkg::USC_CTRL_ADDR) begin
            sw_we  = 8'hFF;
            sw_val = sfr_req_i.wdata;
        end else if (sfr_req_i.bit_wr
                     && sfr_req_i.bit_addr[7:3] == usc_pkg::USC_BIT_BASE) begin
            sw_we  = 8'h01 << sfr_req_i.bit_addr[2:0];
            sw_val = {8{sfr_req_i.bit_val}};
        end
    end

    always_comb begin
        hw_we                      = 8'h00;
        hw_val                     = 8'h00;
        hw_we[usc_pkg::USC_B_RB8]  = rx_load_q;
        hw_val[usc_pkg::USC_B_RB8] = rx_rb8_q;
        hw_we[usc_pkg::USC_B_TI]   = tx_done_q;
        hw_val[usc_pkg::USC_B_TI]  = 1'b1;
        hw_we[usc_pkg::USC_B_RI]   = rx_load_q;
        hw_val[usc_pkg::USC_B_RI]  = 1'b1;
    end

    // ------------------------------------------------------------------
    // control register, one flop per field
    // ------------------------------------------------------------------
    // hardware load beats a software write in the same cycle
    for (genvar i = 0; i < 8; i++) begin : g_ctl
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                ctl_q[i] <= usc_pkg::USC_CTRL_RST[i];
            end else if (hw_we[i]) begin
                ctl_q[i] <= hw_val[i];
            end else if (sw_we[i] && usc_pkg::USC_CTRL_WMASK[i]) begin
                ctl_q[i] <= sw_val[i];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= usc_pkg::USC_UNMAPPED;
        end else if (sfr_req_i.rd) begin
            if (sfr_req_i.addr == usc_pkg::USC_CTRL_ADDR) begin
                rdata_q <= ctl_q | usc_pkg::USC_CTRL_ONES;
            end else if (sfr_req_i.addr == usc_pkg::USC_DATA_ADDR) begin
                rdata_q <= rx_latch_q;
            end else begin
                rdata_q <= usc_pkg::USC_UNMAPPED;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q  <= 1'b0;
            full_q <= 1'b0;
        end else begin
            irq_q  <= ctl_q[usc_pkg::USC_B_TI] | ctl_q[usc_pkg::USC_B_RI];
            full_q <= !fifo_in_ready;
        end
    end

    assign sfr_rdata_o   = rdata_q;
    assign irq_o         = irq_q;
    assign tx_buf_full_o = full_q;

    // ------------------------------------------------------------------
    // transmit path
    // ------------------------------------------------------------------
    // a write while the buffer is full is dropped; software polls full
    assign fifo_in_valid  = sfr_req_i.wr && sfr_req_i.addr == usc_pkg::USC_DATA_ADDR;
    assign fifo_out_ready = (tx_state_q == usc_pkg::USC_IDLE);
    assign tx_bit_end     = baud_x16_i && tx_tick_q == usc_pkg::USC_OVS_LAST;

    usc_fifo #(
        .W (usc_pkg::USC_FIFO_W),
        .D (usc_pkg::USC_FIFO_D)
    ) u_tx_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (sfr_req_i.wdata),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_out_ready),
        .out_data_o  (fifo_out_data)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_state_q <= usc_pkg::USC_IDLE;
            tx_tick_q  <= 4'h0;
            tx_bit_q   <= 3'h0;
            tx_shift_q <= 8'h00;
            tx_q       <= 1'b1;
            tx_done_q  <= 1'b0;
        end else begin
            tx_done_q <= 1'b0;
            if (baud_x16_i) begin
                tx_tick_q <= tx_tick_q + 4'h1;
            end
            case (tx_state_q)
                usc_pkg::USC_IDLE: begin
                    if (fifo_out_valid) begin
                        tx_state_q <= usc_pkg::USC_START;
                        tx_shift_q <= fifo_out_data;
                        tx_tick_q  <= 4'h0;
                        tx_bit_q   <= 3'h0;
                        tx_q       <= 1'b0;
                    end
                end
                usc_pkg::USC_START: begin
                    if (tx_bit_end) begin
                        tx_state_q <= usc_pkg::USC_DATA;
                        tx_q       <= tx_shift_q[0];
                    end
                end
                usc_pkg::USC_DATA: begin
                    if (tx_bit_end) begin
                        tx_shift_q <= tx_shift_q >> 1;
                        tx_bit_q   <= tx_bit_q + 3'h1;
                        if (tx_bit_q != usc_pkg::USC_LAST_BIT) begin
                            tx_q <= tx_shift_q[1];
                        end else if (mode9) begin
                            tx_state_q <= usc_pkg::USC_NINTH;
                            tx_q       <= ctl_q[usc_pkg::USC_B_TB8];
                        end else begin
                            tx_state_q <= usc_pkg::USC_STOP;
                            tx_q       <= 1'b1;
                            tx_done_q  <= 1'b1;
                        end
                    end
                end
                usc_pkg::USC_NINTH: begin
                    if (tx_bit_end) begin
                        tx_state_q <= usc_pkg::USC_STOP;
                        tx_q       <= 1'b1;
                        tx_done_q  <= 1'b1;
                    end
                end
                default: begin
                    if (tx_bit_end) begin
                        tx_state_q <= usc_pkg::USC_IDLE;
                    end
                end
            endcase
        end
    end

    assign tx_o = tx_q;

    // ------------------------------------------------------------------
    // receive path
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            rx_s3_q <= 1'b1;
        end else begin
            rx_s1_q <= rx_i;
            rx_s2_q <= rx_s1_q;
            rx_s3_q <= rx_s2_q;
        end
    end

    // samples land mid-bit: start is checked at half a bit, then every bit
    assign rx_samp      = baud_x16_i && rx_tick_q == usc_pkg::USC_OVS_LAST;
    assign rx_stop_samp = rx_samp && rx_state_q == usc_pkg::USC_STOP;
    assign rx_stop_bit  = rx_s2_q;
    assign rx_check_bit = mode9 ? rx_ninth_q : rx_stop_bit;
    assign rx_accept    = !ctl_q[usc_pkg::USC_B_RI]
                          && (!ctl_q[usc_pkg::USC_B_MCE] || rx_check_bit);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_state_q <= usc_pkg::USC_IDLE;
            rx_tick_q  <= 4'h0;
            rx_bit_q   <= 3'h0;
            rx_shift_q <= 8'h00;
            rx_ninth_q <= 1'b0;
            rx_latch_q <= 8'h00;
            rx_load_q  <= 1'b0;
            rx_rb8_q   <= 1'b0;
        end else begin
            rx_load_q <= 1'b0;
            if (baud_x16_i) begin
                rx_tick_q <= rx_tick_q + 4'h1;
            end
            if (!ctl_q[usc_pkg::USC_B_REN]) begin
                rx_state_q <= usc_pkg::USC_IDLE;
            end else begin
                case (rx_state_q)
                    usc_pkg::USC_IDLE: begin
                        if (rx_s3_q && !rx_s2_q) begin
                            rx_state_q <= usc_pkg::USC_START;
                            rx_tick_q  <= 4'h0;
                            rx_bit_q   <= 3'h0;
                        end
                    end
                    usc_pkg::USC_START: begin
                        if (baud_x16_i && rx_tick_q == usc_pkg::USC_MID) begin
                            rx_tick_q  <= 4'h0;
                            rx_state_q <= rx_s2_q ? usc_pkg::USC_IDLE : usc_pkg::USC_DATA;
                        end
                    end
                    usc_pkg::USC_DATA: begin
                        if (rx_samp) begin
                            rx_shift_q <= {rx_s2_q, rx_shift_q[7:1]};
                            rx_bit_q   <= rx_bit_q + 3'h1;
                            if (rx_bit_q == usc_pkg::USC_LAST_BIT) begin
                                rx_state_q <= mode9 ? usc_pkg::USC_NINTH
                                                    : usc_pkg::USC_STOP;
                            end
                        end
                    end
                    usc_pkg::USC_NINTH: begin
                        if (rx_samp) begin
                            rx_ninth_q <= rx_s2_q;
                            rx_state_q <= usc_pkg::USC_STOP;
                        end
                    end
                    default: begin
                        if (rx_samp) begin
                            rx_state_q <= usc_pkg::USC_IDLE;
                            if (rx_accept) begin
                                rx_latch_q <= rx_shift_q;
                                rx_rb8_q   <= mode9 ? rx_ninth_q : rx_stop_bit;
                                rx_load_q  <= 1'b1;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_tx_begin;
        tx_state_q == usc_pkg::USC_IDLE && fifo_out_valid;
    endsequence
    sequence s_start_low;
        ##1 (tx_state_q == usc_pkg::USC_START && !tx_q);
    endsequence

    property p_tx_start;
        s_tx_begin |-> s_start_low;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("no start bit");
    property p_ninth_tx;
        tx_state_q == usc_pkg::USC_DATA && tx_bit_end
        && tx_bit_q == usc_pkg::USC_LAST_BIT && mode9
        |=> tx_state_q == usc_pkg::USC_NINTH && tx_q == $past(ctl_q[usc_pkg::USC_B_TB8]);
    endproperty
    a_ninth_tx: assert property (p_ninth_tx) else $error("ninth bit wrong");
    property p_eight_stop;
        tx_state_q == usc_pkg::USC_DATA && tx_bit_end
        && tx_bit_q == usc_pkg::USC_LAST_BIT && !mode9
        |=> tx_state_q == usc_pkg::USC_STOP && tx_q && tx_done_q ##1 ctl_q[usc_pkg::USC_B_TI];
    endproperty
    a_eight_stop: assert property (p_eight_stop) else $error("8-bit stop wrong");
    property p_bit6;
        sfr_req_i.rd && sfr_req_i.addr == usc_pkg::USC_CTRL_ADDR
        |=> sfr_rdata_o[usc_pkg::USC_B_RSVD] && ctl_q[usc_pkg::USC_B_RSVD];
    endproperty
    a_bit6: assert property (p_bit6) else $error("bit 6 not one");
    property p_check_bit;
        rx_load_q && ctl_q[usc_pkg::USC_B_MCE] |-> (mode9 ? rx_ninth_q : rx_rb8_q);
    endproperty
    a_check_bit: assert property (p_check_bit) else $error("check bit ignored");
    property p_stop_ok;
        rx_load_q && ctl_q[usc_pkg::USC_B_MCE] && !mode9 |-> rx_rb8_q;
    endproperty
    a_stop_ok: assert property (p_stop_ok) else $error("bad stop accepted");
    property p_ren_off;
        !ctl_q[usc_pkg::USC_B_REN] |=> rx_state_q == usc_pkg::USC_IDLE;
    endproperty
    a_ren_off: assert property (p_ren_off) else $error("rx while disabled");
    property p_rx_load;
        rx_load_q |=> ctl_q[usc_pkg::USC_B_RI] && ctl_q[usc_pkg::USC_B_RB8] == $past(rx_rb8_q);
    endproperty
    a_rx_load: assert property (p_rx_load) else $error("rx flags not loaded");
    property p_flag_hold;
        ctl_q[usc_pkg::USC_B_TI] && !sw_we[usc_pkg::USC_B_TI] |=> ctl_q[usc_pkg::USC_B_TI];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("tx flag lost");
    property p_ri_hold;
        ctl_q[usc_pkg::USC_B_RI] && !sw_we[usc_pkg::USC_B_RI] |=> ctl_q[usc_pkg::USC_B_RI];
    endproperty
    a_ri_hold: assert property (p_ri_hold) else $error("rx flag lost");
    property p_drop;
        rx_stop_samp && ctl_q[usc_pkg::USC_B_RI] |=> !rx_load_q && $stable(rx_latch_q);
    endproperty
    a_drop: assert property (p_drop) else $error("overrun frame kept");
    property p_sw_flag;
        sw_we[usc_pkg::USC_B_TI] && !tx_done_q
        |=> ctl_q[usc_pkg::USC_B_TI] == $past(sw_val[usc_pkg::USC_B_TI]);
    endproperty
    a_sw_flag: assert property (p_sw_flag) else $error("flag write lost");
endmodule // usc_top

// ==== sim/usc_remote.sv ====
// remote serial node model: drives the receive line, decodes the transmit line
// assumes baud_i pulses once per clock pair at sixteen times the bit rate
`timescale 1ns/100ps
module usc_remote (
    input  wire logic clk_i,
    input  wire logic baud_i,
    input  wire logic nine_i,
    input  wire logic line_i,
    output logic      line_o
);
    logic [7:0] got_data;
    logic       got_ninth;
    logic [8:0] sh;
    int         got_cnt;

    initial begin
        line_o = 1'b1;
        got_cnt = 0;
    end

    task automatic ticks(input int n);
        repeat (n) @(posedge clk_i iff baud_i);
    endtask

    // line_o is driven back high after each frame, so idle high between frames
    task automatic send(input logic [7:0] d, input logic n9, input logic stp);
        logic [10:0] f;
        f = nine_i ? {stp, n9, d, 1'b0} : {1'b1, stp, d, 1'b0};
        for (int i = 0; i < (nine_i ? 11 : 10); i++) begin
            line_o <= f[i];
            ticks(16);
        end
        line_o <= 1'b1;
    endtask

    // ---------------------------------------------------------------
    // receiver, samples mid-bit
    // ---------------------------------------------------------------
    always begin
        @(negedge line_i);
        ticks(8);
        for (int i = 0; i < 9; i++) begin
            if (i < 8 || nine_i) begin
                ticks(16);
                sh[i] = line_i;
            end
        end
        ticks(16);
        got_data = sh[7:0];
        got_ninth = sh[8];
        got_cnt++;
    end
endmodule // usc_remote

// ==== sim/uart_serial_control_bench.sv ====
// self-checking bench for the serial port control block
// assumes the remote node model on the serial lines and one clock
`timescale 1ns/100ps
module uart_serial_control_bench;
    logic                  clk_i = 1'b0;
    logic                  rst_i = 1'b1;
    logic                  baud  = 1'b0;
    logic                  nine  = 1'b0;
    usc_pkg::usc_sfr_req_t req   = '0;
    logic [7:0]            rdata;
    logic                  rx;
    logic                  tx;
    logic                  irq;
    logic                  full;
    int                    errors  = 0;
    int                    n_tests = 0;

    always #5 clk_i = ~clk_i;
    always @(negedge clk_i) baud <= ~baud;

    usc_top dut (.clk_i(clk_i), .rst_i(rst_i), .sfr_req_i(req), .sfr_rdata_o(rdata),
        .baud_x16_i(baud), .rx_i(rx), .tx_o(tx), .irq_o(irq), .tx_buf_full_o(full));
    usc_remote peer (.clk_i(clk_i), .baud_i(baud), .nine_i(nine), .line_i(tx), .line_o(rx));

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        req.addr = a;
        req.wdata = d;
        req.wr = 1'b1;
        @(negedge clk_i);
        req.wr = 1'b0;
    endtask

    task automatic bw(input int b, input logic v);
        @(negedge clk_i);
        req.bit_addr = 8'h98 + 8'(b);
        req.bit_val = v;
        req.bit_wr = 1'b1;
        @(negedge clk_i);
        req.bit_wr = 1'b0;
    endtask

    // read data held until next read, so look one cycle late
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string m);
        @(negedge clk_i);
        req.addr = a;
        req.rd = 1'b1;
        @(negedge clk_i);
        req.rd = 1'b0;
        @(negedge clk_i);
        chk(rdata, e, m);
    endtask

    task automatic wait_cnt(input int n);
        for (int i = 0; i < 5000 && peer.got_cnt < n; i++)
            @(negedge clk_i);
        chk(8'(peer.got_cnt), 8'(n), "frame count");
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_regs;
        rd(8'h98, 8'h40, "reset value");
        wr(8'h98, 8'h00);
        rd(8'h98, 8'h40, "bit six");
        wr(8'h98, 8'h23);
        rd(8'h98, 8'h63, "flags stored");
        chk({7'h0, irq}, 8'h01, "sw irq");
        bw(4, 1'b1);
        bw(6, 1'b0);
        bw(0, 1'b0);
        rd(8'h98, 8'h72, "bit write");
        rd(8'h55, 8'h00, "unmapped");
        $display("register test done");
    endtask

    task automatic t_tx(input logic [7:0] c, input logic [7:0] d);
        int n;
        n = peer.got_cnt;
        nine = c[7];
        wr(8'h98, c);
        wr(8'h99, d);
        wait_cnt(n + 1);
        chk(peer.got_data, d, "tx data");
        if (c[7]) chk({7'h0, peer.got_ninth}, {7'h0, c[3]}, "ninth");
        rd(8'h98, c | 8'h02, "tx flag");
        chk({7'h0, irq}, 8'h01, "tx irq");
        wr(8'h98, c);
        @(negedge clk_i);
        chk({7'h0, irq}, 8'h00, "irq clear");
        $display("tx test done");
    endtask

    task automatic t_rx(input logic [7:0] c, input logic [7:0] d,
                        input logic n9, input logic stp, input logic acc);
        logic rb;
        nine = c[7];
        wr(8'h98, c);
        peer.send(d, n9, stp);
        rb = c[7] ? n9 : stp;
        rd(8'h98, acc ? (c | {5'h0, rb, 2'b01}) : c, "rx flags");
        if (acc) rd(8'h99, d, "rx data");
        $display("rx test done");
    endtask

    task automatic t_ovr;
        peer.send(8'h11, 1'b1, 1'b1);
        rd(8'h98, 8'hD1, "overrun flags");
        rd(8'h99, 8'h33, "overrun data");
        chk({7'h0, irq}, 8'h01, "rx irq");
        $display("overrun test done");
    endtask

    task automatic t_fifo;
        int n;
        nine = 1'b0;
        wr(8'h98, 8'h40);
        n = peer.got_cnt;
        for (int i = 0; i < 6; i++)
            wr(8'h99, 8'h10 + i[7:0]);
        chk({7'h0, full}, 8'h01, "fifo full");
        wait_cnt(n + 5);
        chk(peer.got_data, 8'h14, "last frame");
        repeat (400) @(negedge clk_i);
        chk(8'(peer.got_cnt), 8'(n + 5), "dropped write");
        chk({7'h0, full}, 8'h00, "fifo empty");
        $display("fifo test done");
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        #300000; // about five times the expected run
        errors++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        repeat (12) @(negedge clk_i);
        rst_i = 1'b0;
        t_regs();
        t_tx(8'h48, 8'hA5);
        t_tx(8'hC8, 8'h3C);
        t_tx(8'hC0, 8'hC3);
        t_rx(8'h50, 8'h5A, 1'b0, 1'b0, 1'b1);
        t_rx(8'h70, 8'h5A, 1'b0, 1'b0, 1'b0);
        t_rx(8'h70, 8'h96, 1'b0, 1'b1, 1'b1);
        t_rx(8'h40, 8'h96, 1'b0, 1'b1, 1'b0);
        t_rx(8'hF0, 8'h69, 1'b0, 1'b1, 1'b0);
        t_rx(8'hF0, 8'h69, 1'b1, 1'b1, 1'b1);
        t_rx(8'hD0, 8'h33, 1'b0, 1'b1, 1'b1);
        t_ovr();
        t_fifo();
        report_and_stop();
    end
endmodule // uart_serial_control_bench
